// ==== inc/scs_pkg.sv ====
package scs_pkg;

  // Register offsets on the register port
  localparam logic [2:0] SCS_OFF_SYS_SEL  = 3'h0;  // system_clock_source_select
  localparam logic [2:0] SCS_OFF_PRESCALE = 3'h1;  // system_prescaler_setting
  localparam logic [2:0] SCS_OFF_FREEZE   = 3'h2;  // clock_settings_freeze
  localparam logic [2:0] SCS_OFF_RTC      = 3'h3;  // realtime_counter_clock_select
  localparam logic [2:0] SCS_OFF_USB      = 3'h4;  // usb_clock_setup
  localparam logic [2:0] SCS_OFF_STATUS   = 3'h5;  // Switch status, read only

  // Reset values
  localparam logic [2:0] SCS_RST_SYS_SEL  = 3'h0;
  localparam logic [6:0] SCS_RST_PRESCALE = 7'h00;
  localparam logic [3:0] SCS_RST_RTC      = 4'h0;
  localparam logic [5:0] SCS_RST_USB      = 6'h00;

  // Field positions
  localparam int SCS_PSA_LSB    = 2;  // first_stage_divide [6:2]
  localparam int SCS_PSBC_LSB   = 0;  // second_third_stage_divide [1:0]
  localparam int SCS_COUNTER_SOURCE_SELECT_LSB = 1;  // counter_source_select [3:1]
  localparam int SCS_COUNTER_SOURCE_ENABLE_BIT  = 0;  // counter_source_enable
  localparam int SCS_USBDIV_LSB = 3;  // usb_divide_factor [5:3]
  localparam int SCS_USB_SOURCE_SELECT_LSB = 1;  // usb_source_select [2:1]
  localparam int SCS_USBEN_BIT  = 0;  // usb_source_enable
  localparam int SCS_FREEZE_BIT = 0;  // Freeze bit
  localparam int SCS_STAT_BUSY  = 0;  // Status: switch in progress
  localparam int SCS_STAT_ACT   = 1;  // Status: active source [3:1]

  // System clock source codes
  localparam logic [2:0] SCS_SRC_RC2M  = 3'h0;
  localparam logic [2:0] SCS_SRC_RC32M = 3'h1;
  localparam logic [2:0] SCS_SRC_RC32K = 3'h2;
  localparam logic [2:0] SCS_SRC_EXT   = 3'h3;
  localparam logic [2:0] SCS_SRC_PLL   = 3'h4;
  localparam int         SCS_NUM_SRC   = 5;

  // Largest valid first stage code and largest usb divide code
  localparam logic [4:0] SCS_PSA_MAX    = 5'h11;
  localparam logic [2:0] SCS_USBDIV_MAX = 3'h5;

  // Clock switch edge counts on old and new source
  localparam logic [1:0] SCS_OLD_EDGES = 2'h2;
  localparam logic [1:0] SCS_NEW_EDGES = 2'h2;

  // Clock switch sequencer
  typedef enum logic [1:0] {
    SCS_SW_IDLE = 2'b00,
    SCS_SW_OLD  = 2'b01,
    SCS_SW_NEW  = 2'b10
  } scs_sw_state_t;

endpackage

// ==== rtl/scs_div_stage.sv ====
`timescale 1ns/1ps
// One prescaler stage: divides an upstream tick train by 2**shift
module scs_div_stage (
  // Clock and reset
  input  wire logic       clk_sys_in,
  input  wire logic       srst_in,
  // Upstream tick and ratio
  input  wire logic       tick_in,
  input  wire logic [3:0] shift_in,
  // Divided tick
  output logic            tick_out
);
  logic [8:0] count_reg;   // Upstream ticks seen in this period
  logic [3:0] shift_reg;   // Ratio in force
  logic [8:0] last_count;  // Terminal count for the ratio in force
  logic       wrap;        // Last upstream tick of a period

  assign last_count = 9'((10'h001 << shift_reg) - 10'h001);
  assign wrap       = tick_in && (count_reg == last_count);

  // Period counter
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      count_reg <= 9'h000;
    end else if (wrap) begin
      count_reg <= 9'h000;
    end else if (tick_in) begin
      count_reg <= count_reg + 9'h001;
    end
  end

  // A new ratio is taken only at a period boundary, so no short pulse ever appears
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      shift_reg <= 4'h0;
    end else if (wrap) begin
      shift_reg <= shift_in;
    end
  end

  // Registered output tick
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      tick_out <= 1'b0;
    end else begin
      tick_out <= wrap;
    end
  end
endmodule

// ==== rtl/scs_clock_ctrl.sv ====
`timescale 1ns/1ps
module scs_clock_ctrl
  import scs_pkg::*;
(
  // Clock and reset
  input  wire logic                            clk_sys_in,
  input  wire logic                            srst_in,
  // Register port
  input  wire logic [2:0]                      reg_addr_in,
  input  wire logic [7:0]                      reg_wdata_in,
  input  wire logic                            reg_wr_in,
  input  wire logic                            reg_rd_in,
  output logic [7:0]                           reg_rdata_out,
  // Timed unlock window from the protection logic, same clock
  input  wire logic                            ccp_open_in,
  // Oscillator ready flags and raw source clocks, asynchronous
  input  wire logic [scs_pkg::SCS_NUM_SRC-1:0] src_ready_in,
  input  wire logic [scs_pkg::SCS_NUM_SRC-1:0] src_clk_in,
  // System clock selection
  output logic [2:0]                           sys_source_out,
  output logic                                 switch_busy_out,
  output logic [scs_pkg::SCS_NUM_SRC-1:0]      src_hold_out,
  // Prescaler clock enables
  output logic                                 per4_tick_out,
  output logic                                 per2_tick_out,
  output logic                                 cpu_tick_out,
  // Real-time counter clock
  output logic [2:0]                           counter_source_out,
  output logic                                 counter_clock_enable_out,
  // Usb clock
  output logic [1:0]                           usb_source_out,
  output logic [2:0]                           usb_divide_out,
  output logic                                 usb_clock_enable_out
);
  import scs_pkg::*;

  // Decode of a first stage code into a shift; valid codes are zero and odd up to the maximum
  function automatic logic psa_valid(input logic [4:0] code);
    psa_valid = (code == 5'h00) || (code[0] && (code <= SCS_PSA_MAX));
  endfunction

  function automatic logic [3:0] psa_shift(input logic [4:0] code);
    psa_shift = (code == 5'h00) ? 4'h0 : 4'(({1'b0, code} + 6'h01) >> 1);
  endfunction

  // Register state
  logic [2:0]    sys_sel_reg;      // Requested system source
  logic [2:0]    active_src_reg;   // Source actually clocking the system
  logic [2:0]    old_src_reg;      // Source being left during a switch
  logic [4:0]    psa_reg;          // first_stage_divide
  logic [1:0]    psbc_reg;         // second_third_stage_divide
  logic          freeze_reg;       // Freeze bit
  logic [2:0]    rtc_src_reg;      // counter_source_select
  logic          rtc_en_reg;       // counter_source_enable
  logic [2:0]    usb_div_reg;      // usb_divide_factor
  logic [1:0]    usb_src_reg;      // usb_source_select
  logic          usb_en_reg;       // usb_source_enable
  logic [7:0]    rdata_reg;        // Read data, valid one cycle after the strobe
  scs_sw_state_t sw_state_reg;     // Switch sequencer
  logic [1:0]    edge_cnt_reg;     // Edges counted in the current switch phase

  // Synchronisers
  logic [SCS_NUM_SRC-1:0] rdy_meta_reg;  // First stage, read only by the second
  logic [SCS_NUM_SRC-1:0] rdy_sync_reg;
  logic [SCS_NUM_SRC-1:0] clk_meta_reg;  // First stage, read only by the second
  logic [SCS_NUM_SRC-1:0] clk_sync_reg;
  logic [SCS_NUM_SRC-1:0] clk_prev_reg;
  logic [SCS_NUM_SRC-1:0] src_rise;      // Rising edge of each source clock

  // Write qualifiers
  logic wr_sys;        // Write to the source select register
  logic wr_ps;         // Write to the prescaler register
  logic wr_frz;        // Write to the freeze register
  logic wr_rtc;        // Write to the counter clock register
  logic wr_usb;        // Write to the usb clock register
  logic prot_ok;       // Protected write allowed at all
  logic [2:0] new_sel; // Requested source in the write data
  logic sel_ok;        // Requested source is legal and stable
  logic old_rise;      // Edge of the source being left
  logic new_rise;      // Edge of the source being entered

  assign wr_sys   = reg_wr_in && (reg_addr_in == SCS_OFF_SYS_SEL);
  assign wr_ps    = reg_wr_in && (reg_addr_in == SCS_OFF_PRESCALE);
  assign wr_frz   = reg_wr_in && (reg_addr_in == SCS_OFF_FREEZE);
  assign wr_rtc   = reg_wr_in && (reg_addr_in == SCS_OFF_RTC);
  assign wr_usb   = reg_wr_in && (reg_addr_in == SCS_OFF_USB);
  assign prot_ok  = ccp_open_in && !freeze_reg;
  assign new_sel  = reg_wdata_in[2:0];
  // Busy switches also refuse a new request, so one switch never overlaps another
  assign sel_ok   = (new_sel <= SCS_SRC_PLL) && rdy_sync_reg[new_sel] &&
                    (sw_state_reg == SCS_SW_IDLE);
  assign src_rise = clk_sync_reg & ~clk_prev_reg;
  assign old_rise = src_rise[old_src_reg];
  assign new_rise = src_rise[sys_sel_reg];

  // Two flop synchronisers for the ready flags and source clocks
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      rdy_meta_reg <= '0;
      rdy_sync_reg <= '0;
      clk_meta_reg <= '0;
      clk_sync_reg <= '0;
      clk_prev_reg <= '0;
    end else begin
      rdy_meta_reg <= src_ready_in;
      rdy_sync_reg <= rdy_meta_reg;
      clk_meta_reg <= src_clk_in;
      clk_sync_reg <= clk_meta_reg;
      clk_prev_reg <= clk_sync_reg;
    end
  end

  // Source select register; the requested code is held even while the switch runs
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      sys_sel_reg <= SCS_RST_SYS_SEL;
    end else if (wr_sys && prot_ok && sel_ok) begin
      sys_sel_reg <= new_sel;
    end
  end

  // Switch sequencer: old source edges first, then new source edges
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      sw_state_reg   <= SCS_SW_IDLE;
      edge_cnt_reg   <= 2'h0;
      active_src_reg <= SCS_RST_SYS_SEL;
      old_src_reg    <= SCS_RST_SYS_SEL;
    end else begin
      case (sw_state_reg)
        SCS_SW_IDLE: begin
          // Same source requested again needs no switch
          if (sys_sel_reg != active_src_reg) begin
            sw_state_reg <= SCS_SW_OLD;
            old_src_reg  <= active_src_reg;
            edge_cnt_reg <= 2'h0;
          end
        end
        SCS_SW_OLD: begin
          if (old_rise) begin
            if (edge_cnt_reg == SCS_OLD_EDGES - 2'h1) begin
              sw_state_reg <= SCS_SW_NEW;
              edge_cnt_reg <= 2'h0;
            end else begin
              edge_cnt_reg <= edge_cnt_reg + 2'h1;
            end
          end
        end
        SCS_SW_NEW: begin
          if (new_rise) begin
            if (edge_cnt_reg == SCS_NEW_EDGES - 2'h1) begin
              sw_state_reg   <= SCS_SW_IDLE;
              active_src_reg <= sys_sel_reg;
              old_src_reg    <= sys_sel_reg;
              edge_cnt_reg   <= 2'h0;
            end else begin
              edge_cnt_reg <= edge_cnt_reg + 2'h1;
            end
          end
        end
        default: begin
          sw_state_reg <= SCS_SW_IDLE;
        end
      endcase
    end
  end

  // Prescaler register; reserved first stage codes are refused
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      psa_reg  <= SCS_RST_PRESCALE[6:2];
      psbc_reg <= SCS_RST_PRESCALE[1:0];
    end else if (wr_ps && prot_ok) begin
      if (psa_valid(reg_wdata_in[SCS_PSA_LSB +: 5])) begin
        psa_reg <= reg_wdata_in[SCS_PSA_LSB +: 5];
      end
      psbc_reg <= reg_wdata_in[SCS_PSBC_LSB +: 2];
    end
  end

  // Freeze bit: set only, cleared by reset alone
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      freeze_reg <= 1'b0;
    end else if (wr_frz && ccp_open_in && reg_wdata_in[SCS_FREEZE_BIT]) begin
      freeze_reg <= 1'b1;
    end
  end

  // Counter clock register; reserved source codes leave the source unchanged
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      rtc_src_reg <= SCS_RST_RTC[3:1];
      rtc_en_reg  <= SCS_RST_RTC[0];
    end else if (wr_rtc) begin
      if (reg_wdata_in[3:1] != 3'h3 && reg_wdata_in[3:1] != 3'h4) begin
        rtc_src_reg <= reg_wdata_in[SCS_COUNTER_SOURCE_SELECT_LSB +: 3];
      end
      rtc_en_reg <= reg_wdata_in[SCS_COUNTER_SOURCE_ENABLE_BIT];
    end
  end

  // Usb clock register; the divide field is frozen while the source is enabled
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      usb_div_reg <= SCS_RST_USB[5:3];
      usb_src_reg <= SCS_RST_USB[2:1];
      usb_en_reg  <= SCS_RST_USB[0];
    end else if (wr_usb) begin
      if (!usb_en_reg && reg_wdata_in[SCS_USBDIV_LSB +: 3] <= SCS_USBDIV_MAX) begin
        usb_div_reg <= reg_wdata_in[SCS_USBDIV_LSB +: 3];
      end
      if (!reg_wdata_in[2]) begin
        usb_src_reg <= reg_wdata_in[SCS_USB_SOURCE_SELECT_LSB +: 2];
      end
      usb_en_reg <= reg_wdata_in[SCS_USBEN_BIT];
    end
  end

  // Read data one cycle after the strobe; reserved bits and unmapped offsets read zero
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      rdata_reg <= 8'h00;
    end else if (!reg_rd_in) begin
      rdata_reg <= 8'h00;
    end else if (reg_addr_in == SCS_OFF_SYS_SEL) begin
      rdata_reg <= {5'h00, sys_sel_reg};
    end else if (reg_addr_in == SCS_OFF_PRESCALE) begin
      rdata_reg <= {1'b0, psa_reg, psbc_reg};
    end else if (reg_addr_in == SCS_OFF_FREEZE) begin
      rdata_reg <= {7'h00, freeze_reg};
    end else if (reg_addr_in == SCS_OFF_RTC) begin
      rdata_reg <= {4'h0, rtc_src_reg, rtc_en_reg};
    end else if (reg_addr_in == SCS_OFF_USB) begin
      rdata_reg <= {2'h0, usb_div_reg, usb_src_reg, usb_en_reg};
    end else if (reg_addr_in == SCS_OFF_STATUS) begin
      rdata_reg <= {4'h0, active_src_reg, (sw_state_reg != SCS_SW_IDLE)};
    end else begin
      rdata_reg <= 8'h00;
    end
  end

  // Prescaler chain as clock enables on the system clock; one stage module per stage
  logic [3:0] shift_b;  // Second stage ratio
  logic [3:0] shift_c;  // Third stage ratio
  assign shift_b = (psbc_reg == 2'h2) ? 4'h2 : ((psbc_reg == 2'h3) ? 4'h1 : 4'h0);
  assign shift_c = psbc_reg[0] ? 4'h1 : 4'h0;

  scs_div_stage u_stage_a (
    .clk_sys_in (clk_sys_in),
    .srst_in    (srst_in),
    .tick_in    (1'b1),
    .shift_in   (psa_shift(psa_reg)),
    .tick_out   (per4_tick_out)
  );

  scs_div_stage u_stage_b (
    .clk_sys_in (clk_sys_in),
    .srst_in    (srst_in),
    .tick_in    (per4_tick_out),
    .shift_in   (shift_b),
    .tick_out   (per2_tick_out)
  );

  scs_div_stage u_stage_c (
    .clk_sys_in (clk_sys_in),
    .srst_in    (srst_in),
    .tick_in    (per2_tick_out),
    .shift_in   (shift_c),
    .tick_out   (cpu_tick_out)
  );

  // Outputs
  assign reg_rdata_out            = rdata_reg;
  assign sys_source_out           = active_src_reg;
  assign switch_busy_out          = (sw_state_reg != SCS_SW_IDLE);
  // Both ends of a switch stay held so neither can be turned off mid switch
  assign src_hold_out             = 5'(5'h01 << active_src_reg) | 5'(5'h01 << sys_sel_reg);
  assign counter_source_out       = rtc_src_reg;
  assign counter_clock_enable_out = rtc_en_reg;
  assign usb_source_out           = usb_src_reg;
  assign usb_divide_out           = usb_div_reg;
  assign usb_clock_enable_out     = usb_en_reg;

  // Checks
  a_unstable_refused: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    wr_sys && !rdy_sync_reg[new_sel] |=> $stable(sys_sel_reg)) else $error("unstable source accepted");
  a_reserved_sel: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    wr_sys && new_sel > SCS_SRC_PLL |=> sys_sel_reg == $past(sys_sel_reg)) else $error("reserved source taken");
  a_unprotected_write: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    (wr_sys || wr_ps) && !ccp_open_in |=> $stable(sys_sel_reg) && $stable(psa_reg)) else $error("unguarded write");
  a_freeze_blocks: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    freeze_reg && wr_ps |=> $stable(psa_reg) && $stable(psbc_reg)) else $error("frozen prescaler changed");
  a_freeze_sticky: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    freeze_reg |=> freeze_reg) else $error("freeze bit cleared");
  a_switch_length: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    $rose(switch_busy_out) |-> switch_busy_out [*4]) else $error("switch too short");
  a_old_held: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    switch_busy_out |-> src_hold_out[old_src_reg] && src_hold_out[sys_sel_reg]) else $error("old source released");
  a_usb_div_frozen: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    usb_en_reg && wr_usb |=> usb_div_reg == $past(usb_div_reg)) else $error("usb divide changed");
  a_per4_full_rate: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    psa_reg == 5'h00 && $past(psa_reg, 2) == 5'h00 && per4_tick_out |=> per4_tick_out) else $error("no division broken");
endmodule

// ==== tb/scs_clock_ctrl_tb.sv ====
`timescale 1ns/1ps
module scs_clock_ctrl_tb;
  import scs_pkg::*;
  // Stimulus, all driven by the bench
  logic                   clk_sys   = 1'b0;
  logic                   srst      = 1'b1;
  logic [2:0]             reg_addr  = 3'h0;
  logic [7:0]             reg_wdata = 8'h00;
  logic                   reg_wr    = 1'b0;
  logic                   reg_rd    = 1'b0;
  logic                   ccp_open  = 1'b0;
  logic [SCS_NUM_SRC-1:0] src_ready = 5'h1D;  // Source 1 starts not ready
  logic [SCS_NUM_SRC-1:0] src_clk   = 5'h00;  // Source clocks still until a switch
  // Observed outputs
  logic [7:0]             reg_rdata;
  logic [2:0]             sys_source;
  logic                   switch_busy;
  logic [SCS_NUM_SRC-1:0] src_hold;
  logic                   per4_tick;
  logic                   per2_tick;
  logic                   cpu_tick;
  logic [2:0]             counter_source;
  logic                   counter_en;
  logic [1:0]             usb_source;
  logic [2:0]             usb_divide;
  logic                   usb_en;
  // Bookkeeping
  int                     mismatches  = 0;
  int                     checks_done = 0;
  logic [7:0]             rd_val;
  logic [2:0]             last_src;
  int                     per;
  int                     k;
  int                     b_div[4]   = '{1, 1, 4, 2};
  int                     c_div[4]   = '{1, 2, 1, 2};
  logic [2:0]             sw_seq[5]  = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h0};
  logic [7:0]             usb_w[7]   = '{8'h2A, 8'h19, 8'h09, 8'h1D, 8'h18, 8'h30, 8'h28};
  logic [7:0]             usb_e[7]   = '{8'h2A, 8'h19, 8'h19, 8'h19, 8'h18, 8'h18, 8'h28};

  // Free running system clock, 25 ns
  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end

  scs_clock_ctrl DUT (
    .clk_sys_in(clk_sys), .srst_in(srst), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
    .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata), .ccp_open_in(ccp_open),
    .src_ready_in(src_ready), .src_clk_in(src_clk), .sys_source_out(sys_source),
    .switch_busy_out(switch_busy), .src_hold_out(src_hold), .per4_tick_out(per4_tick),
    .per2_tick_out(per2_tick), .cpu_tick_out(cpu_tick), .counter_source_out(counter_source),
    .counter_clock_enable_out(counter_en), .usb_source_out(usb_source),
    .usb_divide_out(usb_divide), .usb_clock_enable_out(usb_en)
  );

  // Verdict and end of run, also reached by an exhausted wait
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Single comparison point; case inequality so unknowns never match
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One-cycle write; the unlock window rides along with the strobe
  task automatic reg_write(input logic [2:0] a, input logic [7:0] d, input logic c);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    ccp_open  <= c;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
    ccp_open  <= 1'b0;
  endtask

  // One-cycle read; data stand only in the following cycle
  task automatic reg_read(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // Read and compare in one call
  task automatic read_expect(input string name, input logic [2:0] a, input logic [7:0] e);
    logic [7:0] d;
    reg_read(a, d);
    check(name, {8'h00, d}, {8'h00, e});
  endtask

  // One slow rising edge on a source clock; long enough for the synchronisers
  task automatic src_edge(input int idx);
    @(posedge clk_sys);
    src_clk[idx] <= 1'b1;
    repeat (4) @(posedge clk_sys);
    src_clk[idx] <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask

  function automatic logic tick_of(input int w);
    return (w == 0) ? per4_tick : ((w == 1) ? per2_tick : cpu_tick);
  endfunction

  // Cycles between two consecutive ticks of one stage, bounded
  task automatic tick_period(input int w, output int n);
    int i;
    i = 0;
    do begin @(posedge clk_sys); #1; i++; end while (tick_of(w) !== 1'b1 && i < 1100);
    n = 0;
    do begin @(posedge clk_sys); #1; n++; end while (tick_of(w) !== 1'b1 && n < 1100);
    if (n >= 1100) begin
      mismatches++;
      print_verdict();
    end
  endtask

  // Full source switch: sys_source keeps the old source until two old then two new edges
  task automatic do_switch(input logic [2:0] from, input logic [2:0] to);
    int i;
    reg_write(SCS_OFF_SYS_SEL, {5'h00, to}, 1'b1);
    repeat (2) @(posedge clk_sys);
    #1;
    check("busy", {15'h0, switch_busy}, 16'h0001);
    check("hold both", {11'h0, src_hold}, {11'h0, (5'h01 << from) | (5'h01 << to)});
    read_expect("status busy", SCS_OFF_STATUS, {4'h0, from, 1'b1});
    // A second select while switching is refused
    reg_write(SCS_OFF_SYS_SEL, {5'h00, from}, 1'b1);
    read_expect("select held", SCS_OFF_SYS_SEL, {5'h00, to});
    repeat (20) @(posedge clk_sys);
    src_edge(from);
    src_edge(from);
    #1;
    check("old still on", {13'h0, sys_source}, {13'h0, from});
    check("still busy", {15'h0, switch_busy}, 16'h0001);
    src_edge(to);
    src_edge(to);
    i = 0;
    while (switch_busy !== 1'b0 && i < 20) begin @(posedge clk_sys); #1; i++; end
    if (i >= 20) begin
      mismatches++;
      print_verdict();
    end
    check("new source", {13'h0, sys_source}, {13'h0, to});
    check("hold new", {11'h0, src_hold}, {11'h0, 5'h01 << to});
  endtask

  // Main sequence
  initial begin
    repeat (6) @(posedge clk_sys);
    srst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    // Reset values, status and the two unmapped offsets read zero
    for (k = 0; k < 8; k++) read_expect("reset read", k[2:0], 8'h00);
    check("hold idle", {11'h0, src_hold}, 16'h0001);
    // Selection without the unlock window, then an unstable source
    reg_write(SCS_OFF_SYS_SEL, 8'h02, 1'b0);
    read_expect("no unlock", SCS_OFF_SYS_SEL, 8'h00);
    reg_write(SCS_OFF_SYS_SEL, 8'h01, 1'b1);
    read_expect("not ready", SCS_OFF_SYS_SEL, 8'h00);
    @(posedge clk_sys);
    src_ready <= 5'h1F;
    repeat (4) @(posedge clk_sys);
    do_switch(3'h0, sw_seq[0]);
    // Reserved codes leave the selection alone
    for (k = 5; k < 8; k++) begin
      reg_write(SCS_OFF_SYS_SEL, k[7:0], 1'b1);
      read_expect("reserved sel", SCS_OFF_SYS_SEL, 8'h01);
    end
    for (k = 1; k < 5; k++) do_switch(sw_seq[k-1], sw_seq[k]);
    // First stage: every valid code, period doubles per step
    for (k = 0; k < 10; k++) begin
      reg_write(SCS_OFF_PRESCALE, {1'b0, (k == 0) ? 5'h00 : 5'(2 * k - 1), 2'b00}, 1'b1);
      tick_period(0, per);
      tick_period(0, per);
      check("per4 period", per[15:0], 16'(1 << k));
    end
    // Reserved first stage codes keep the old ratio, second field still taken
    reg_write(SCS_OFF_PRESCALE, 8'h4D, 1'b1);
    read_expect("psa odd high", SCS_OFF_PRESCALE, 8'h45);
    reg_write(SCS_OFF_PRESCALE, 8'h0A, 1'b1);
    read_expect("psa even", SCS_OFF_PRESCALE, 8'h46);
    // Prescaler write outside the unlock window is ignored
    reg_write(SCS_OFF_PRESCALE, 8'h07, 1'b0);
    read_expect("psc no unlock", SCS_OFF_PRESCALE, 8'h46);
    // Second and third stage codes, chained behind the first
    for (k = 0; k < 4; k++) begin
      reg_write(SCS_OFF_PRESCALE, {6'h00, k[1:0]}, 1'b1);
      tick_period(1, per);
      tick_period(1, per);
      check("per2 period", per[15:0], 16'(b_div[k]));
      tick_period(2, per);
      tick_period(2, per);
      check("cpu period", per[15:0], 16'(b_div[k] * c_div[k]));
    end
    // Counter clock source: all codes, reserved ones refused
    last_src = 3'h0;
    for (k = 0; k < 8; k++) begin
      reg_write(SCS_OFF_RTC, {4'h0, k[2:0], 1'b1}, 1'b0);
      if (k != 3 && k != 4) last_src = k[2:0];
      read_expect("rtc reg", SCS_OFF_RTC, {4'h0, last_src, 1'b1});
      check("rtc src", {13'h0, counter_source}, {13'h0, last_src});
      check("rtc on", {15'h0, counter_en}, 16'h0001);
    end
    reg_write(SCS_OFF_RTC, 8'h00, 1'b0);
    #1;
    check("rtc off", {15'h0, counter_en}, 16'h0000);
    // Usb setup table: divide locked while enabled, reserved codes refused
    for (k = 0; k < 7; k++) begin
      reg_write(SCS_OFF_USB, usb_w[k], 1'b0);
      read_expect("usb reg", SCS_OFF_USB, usb_e[k]);
      check("usb out", {8'h00, 2'b00, usb_divide, usb_source, usb_en}, {8'h00, usb_e[k]});
    end
    // Freeze: needs the window, blocks selection and prescaler, cannot be cleared
    reg_write(SCS_OFF_FREEZE, 8'h01, 1'b0);
    read_expect("freeze locked", SCS_OFF_FREEZE, 8'h00);
    reg_write(SCS_OFF_FREEZE, 8'h01, 1'b1);
    read_expect("freeze set", SCS_OFF_FREEZE, 8'h01);
    reg_write(SCS_OFF_SYS_SEL, 8'h01, 1'b1);
    read_expect("frozen sel", SCS_OFF_SYS_SEL, 8'h00);
    check("no switch", {15'h0, switch_busy}, 16'h0000);
    reg_write(SCS_OFF_PRESCALE, 8'h05, 1'b1);
    read_expect("frozen psc", SCS_OFF_PRESCALE, 8'h03);
    reg_write(SCS_OFF_FREEZE, 8'h00, 1'b1);
    read_expect("freeze stays", SCS_OFF_FREEZE, 8'h01);
    // Only a reset clears the freeze
    @(posedge clk_sys);
    srst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    read_expect("freeze reset", SCS_OFF_FREEZE, 8'h00);
    read_expect("psc reset", SCS_OFF_PRESCALE, 8'h00);
    print_verdict();
  end
endmodule
